// *** rtl/fpc_fan_pwm.sv ***
// Purpose: fan pwm control registers, table lookup, startup sequencing
// Assumes: register port strobes are one-cycle, synchronous to mclk
// Notes: read data appears one cycle after reg_rd; tach counting lives elsewhere
`timescale 1ns/10ps
`default_nettype none
module fpc_fan_pwm #(
  parameter int unsigned SLOW_TICK_CYC = fpc_pkg::SLOW_TICK_CYC_DEF,
  parameter int unsigned SPINUP_UNIT_CYC = fpc_pkg::SPINUP_UNIT_CYC_DEF
)(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] remote_temp,
  input wire logic tach_min_reached,
  input wire logic pwm_pin_in,
  output logic pwm_pin_out,
  output logic pwm_pin_oe,
  output logic [1:0] tach_mode,
  output logic spinup_busy
);
  typedef struct packed {
    fpc_pkg::fpc_state_t st;
    logic manual;
    logic pol;
    logic clk_slow;
    logic [1:0] mode;
    logic tach_term;
    logic [1:0] su_duty_code;
    logic [2:0] su_time;
    logic [5:0] duty_man;
    logic [4:0] div_n;
    logic [7:0][6:0] lut_temp;
    logic [7:0][5:0] lut_duty;
    logic [26:0] su_cnt;
    logic prev_zero;
    logic [5:0] duty_eff;
    logic [7:0] rdata;
    logic [1:0] tach_mode;
    logic busy;
  } fpc_top_s_t;

  fpc_top_s_t s;
  fpc_top_s_t next_s;
  fpc_pwm_if pw ();

  logic [7:0] hit;
  logic [5:0] lut_sel;
  logic [5:0] cmd_duty;
  logic [5:0] su_duty;
  logic [26:0] su_len;
  logic su_start;
  logic su_done;
  logic [7:0] rd_mux;
  logic lut_acc;
  logic [2:0] lut_idx;

  // per-entry temperature compare; negative temperatures never exceed an entry
  for (genvar gi = 0; gi < fpc_pkg::LUT_ENTRIES; gi++)
  begin : g_lut
    assign hit[gi] = ~remote_temp[7] && (remote_temp[6:0] > s.lut_temp[gi]);
  end

  // highest matching entry wins, as tables are laid out in rising temperature
  always_comb
  begin
    lut_sel = 6'h00;
    for (int i = 0; i < fpc_pkg::LUT_ENTRIES; i++)
    begin
      if (hit[i])
      begin
        lut_sel = s.lut_duty[i];
      end
    end
  end

  always_comb
  begin
    cmd_duty = s.manual ? s.duty_man : lut_sel;
    case (s.su_duty_code)
      2'h1: su_duty = fpc_pkg::DUTY_HALF;
      2'h2: su_duty = fpc_pkg::DUTY_78;
      2'h3: su_duty = fpc_pkg::DUTY_FULL;
      default: su_duty = 6'h00;
    endcase
    if (s.tach_term)
    begin
      su_duty = fpc_pkg::DUTY_FULL;
    end
    su_len = 27'(SPINUP_UNIT_CYC) << (s.su_time - 3'h1);
    su_start = s.prev_zero && (cmd_duty != 6'h00) && (s.su_time != 3'h0)
      && (s.tach_term || (s.su_duty_code != 2'h0));
    su_done = (s.su_cnt <= 27'h0000001) || (s.tach_term && tach_min_reached)
      || (cmd_duty == 6'h00);
  end

  always_comb
  begin
    lut_acc = (reg_addr >= fpc_pkg::ADDR_LUT_FIRST) && (reg_addr <= fpc_pkg::ADDR_LUT_LAST);
    lut_idx = reg_addr[3:1];
    rd_mux = 8'h00;
    case (reg_addr)
      fpc_pkg::ADDR_CFG:
      begin
        rd_mux[fpc_pkg::CFG_MANUAL_BIT] = s.manual;
        rd_mux[fpc_pkg::CFG_POL_BIT] = s.pol;
        rd_mux[fpc_pkg::CFG_CLK_BIT] = s.clk_slow;
        rd_mux[fpc_pkg::CFG_MODE_LSB +: 2] = s.mode;
      end
      fpc_pkg::ADDR_SU:
      begin
        rd_mux[fpc_pkg::SU_TERM_BIT] = s.tach_term;
        rd_mux[fpc_pkg::SU_DUTY_LSB +: 2] = s.su_duty_code;
        rd_mux[fpc_pkg::SU_TIME_LSB +: 3] = s.su_time;
      end
      fpc_pkg::ADDR_DUTY:
      begin
        rd_mux[5:0] = (s.st == fpc_pkg::FPC_SPIN) ? 6'h00 : cmd_duty;
      end
      fpc_pkg::ADDR_DIV:
      begin
        rd_mux[4:0] = s.div_n;
      end
      default:
      begin
        if (lut_acc)
        begin
          if (reg_addr[0])
          begin
            rd_mux[5:0] = s.lut_duty[lut_idx];
          end
          else
          begin
            rd_mux[6:0] = s.lut_temp[lut_idx];
          end
        end
      end
    endcase
  end

  always_comb
  begin
    next_s = s;
    if (reg_rd)
    begin
      next_s.rdata = rd_mux;
    end
    if (reg_wr)
    begin
      case (reg_addr)
        fpc_pkg::ADDR_CFG:
        begin
          // reserved bit 2 is not stored, so it always reads back zero
          next_s.manual = reg_wdata[fpc_pkg::CFG_MANUAL_BIT];
          next_s.pol = reg_wdata[fpc_pkg::CFG_POL_BIT];
          next_s.clk_slow = reg_wdata[fpc_pkg::CFG_CLK_BIT];
          next_s.mode = reg_wdata[fpc_pkg::CFG_MODE_LSB +: 2];
        end
        fpc_pkg::ADDR_SU:
        begin
          next_s.tach_term = reg_wdata[fpc_pkg::SU_TERM_BIT];
          next_s.su_duty_code = reg_wdata[fpc_pkg::SU_DUTY_LSB +: 2];
          next_s.su_time = reg_wdata[fpc_pkg::SU_TIME_LSB +: 3];
        end
        fpc_pkg::ADDR_DUTY:
        begin
          if (s.manual)
          begin
            next_s.duty_man = reg_wdata[5:0];
          end
        end
        fpc_pkg::ADDR_DIV:
        begin
          next_s.div_n = reg_wdata[4:0];
        end
        default:
        begin
          if (lut_acc && s.manual)
          begin
            if (reg_addr[0])
            begin
              next_s.lut_duty[lut_idx] = reg_wdata[5:0];
            end
            else
            begin
              next_s.lut_temp[lut_idx] = reg_wdata[6:0];
            end
          end
        end
      endcase
    end

    next_s.prev_zero = (cmd_duty == 6'h00);
    case (s.st)
      fpc_pkg::FPC_IDLE:
      begin
        next_s.duty_eff = cmd_duty;
        if (su_start)
        begin
          next_s.st = fpc_pkg::FPC_SPIN;
          next_s.su_cnt = su_len;
          next_s.duty_eff = su_duty;
        end
      end
      fpc_pkg::FPC_SPIN:
      begin
        next_s.duty_eff = su_duty;
        next_s.su_cnt = s.su_cnt - 27'h0000001;
        if (su_done)
        begin
          next_s.st = fpc_pkg::FPC_IDLE;
          next_s.su_cnt = '0;
          next_s.duty_eff = cmd_duty;
        end
      end
      default:
      begin
        next_s.st = fpc_pkg::FPC_IDLE;
      end
    endcase
    next_s.busy = (next_s.st == fpc_pkg::FPC_SPIN);
    // the fast clock cannot resolve the other tach methods
    next_s.tach_mode = next_s.clk_slow ? next_s.mode : fpc_pkg::MODE_TRAD;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s.st <= fpc_pkg::FPC_IDLE;
      s.manual <= fpc_pkg::CFG_RST[fpc_pkg::CFG_MANUAL_BIT];
      s.pol <= fpc_pkg::CFG_RST[fpc_pkg::CFG_POL_BIT];
      s.clk_slow <= fpc_pkg::CFG_RST[fpc_pkg::CFG_CLK_BIT];
      s.mode <= fpc_pkg::CFG_RST[fpc_pkg::CFG_MODE_LSB +: 2];
      s.tach_term <= fpc_pkg::SU_RST[fpc_pkg::SU_TERM_BIT];
      s.su_duty_code <= fpc_pkg::SU_RST[fpc_pkg::SU_DUTY_LSB +: 2];
      s.su_time <= fpc_pkg::SU_RST[fpc_pkg::SU_TIME_LSB +: 3];
      s.duty_man <= fpc_pkg::DUTY_RST;
      s.div_n <= fpc_pkg::DIV_RST;
      s.lut_temp <= {fpc_pkg::LUT_ENTRIES{fpc_pkg::LUT_TEMP_RST}};
      s.lut_duty <= {fpc_pkg::LUT_ENTRIES{fpc_pkg::LUT_DUTY_RST}};
      s.su_cnt <= '0;
      s.prev_zero <= 1'b1;
      s.duty_eff <= 6'h00;
      s.rdata <= 8'h00;
      s.tach_mode <= fpc_pkg::MODE_TRAD;
      s.busy <= 1'b0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign pw.clk_slow = s.clk_slow;
  assign pw.duty = s.duty_eff;
  assign pw.div_n = s.div_n;
  assign pw.pol = s.pol;

  fpc_prescale #(
    .SLOW_TICK_CYC(SLOW_TICK_CYC)
  ) u_pre (
    .mclk(mclk),
    .rst(rst),
    .pw(pw.pre)
  );

  fpc_pwm_core u_core (
    .mclk(mclk),
    .rst(rst),
    .pw(pw.core),
    .pin_out(pwm_pin_out),
    .pin_oe(pwm_pin_oe)
  );

  assign reg_rdata = s.rdata;
  assign tach_mode = s.tach_mode;
  assign spinup_busy = s.busy;
endmodule
`default_nettype wire

// *** rtl/fpc_pkg.sv ***
// Purpose: shared constants and types for the fan pwm control block
// Assumes: 25 MHz mclk; byte-wide register port with 8-bit addresses
// Notes: all offsets, field positions, reset values and cycle counts live here
// Functional notes
// - manual bit clear: duty and table read-only, duty taken from temperature and table
// - manual bit set: duty and table writable, written duty drives output directly
// - polarity 0: pin low means off; polarity 1: pin low means on
// - base clock bit selects 360 kHz (0) or 1.4 kHz (1) pwm master clock
// - two-bit speed sense field selects tach method; codes above 00 report all ones (the code reads the field back as written and passes it to tach_mode)
// - with 360 kHz selected, speed sensing always runs in mode 00
// - speed-terminated bit clear: startup uses programmed duty and duration
// - speed-terminated bit set: 100% duty, ends on timeout or tach speed reached
// - duration code 000 skips startup regardless of speed-terminated bit
// - duration codes 001..111 give 0.05 s doubling up to 3.2 s
// - output frequency is master clock divided by twice the divisor
// - divisor value zero behaves as one
// - manual off: duty register reads table choice, writes ignored
// - duty register reads zero while startup runs
// - unused upper register bits read zero
// - table entry duty applies when remote temperature exceeds its temperature
package fpc_pkg;
  localparam logic [7:0] ADDR_CFG = 8'h4A;
  localparam logic [7:0] ADDR_SU = 8'h4B;
  localparam logic [7:0] ADDR_DUTY = 8'h4C;
  localparam logic [7:0] ADDR_DIV = 8'h4D;
  localparam logic [7:0] ADDR_LUT_FIRST = 8'h50;
  localparam logic [7:0] ADDR_LUT_LAST = 8'h5F;
  localparam logic [7:0] CFG_RST = 8'h20;
  localparam logic [7:0] SU_RST = 8'h3F;
  localparam logic [5:0] DUTY_RST = 6'h00;
  localparam logic [4:0] DIV_RST = 5'h17;
  localparam logic [6:0] LUT_TEMP_RST = 7'h7F;
  localparam logic [5:0] LUT_DUTY_RST = 6'h3F;
  localparam int CFG_MANUAL_BIT = 5;
  localparam int CFG_POL_BIT = 4;
  localparam int CFG_CLK_BIT = 3;
  localparam int CFG_MODE_LSB = 0;
  localparam int SU_TERM_BIT = 5;
  localparam int SU_DUTY_LSB = 3;
  localparam int SU_TIME_LSB = 0;
  localparam int LUT_ENTRIES = 8;
  localparam logic [5:0] DUTY_FULL = 6'h3F;
  localparam logic [5:0] DUTY_HALF = 6'h20;
  localparam logic [5:0] DUTY_78 = 6'h31;
  localparam logic [1:0] MODE_TRAD = 2'h0;
  localparam int unsigned MCLK_HZ = 25_000_000;
  localparam int unsigned PWMCLK_FAST_HZ = 360_000;
  localparam int unsigned PWMCLK_SLOW_HZ = 1_400;
  localparam int unsigned FAST_TICK_CYC = MCLK_HZ / PWMCLK_FAST_HZ;
  localparam int unsigned SLOW_TICK_CYC_DEF = MCLK_HZ / PWMCLK_SLOW_HZ;
  localparam int unsigned SPINUP_UNIT_US = 50_000;
  localparam int unsigned SPINUP_UNIT_CYC_DEF = (MCLK_HZ / 1_000_000) * SPINUP_UNIT_US;
  typedef enum logic [1:0] {FPC_IDLE = 2'h0, FPC_SPIN = 2'h1} fpc_state_t;
endpackage

// *** rtl/fpc_prescale.sv ***
// Purpose: pwm master clock tick from mclk
// Assumes: mclk at 25 MHz
// Notes: tick is a one-cycle pulse at the selected master clock rate
`timescale 1ns/10ps
`default_nettype none
module fpc_prescale #(
  parameter int unsigned SLOW_TICK_CYC = fpc_pkg::SLOW_TICK_CYC_DEF
)(
  input wire logic mclk,
  input wire logic rst,
  fpc_pwm_if.pre pw
);
  typedef struct packed {
    logic [14:0] cnt;
    logic tick;
  } fpc_pre_s_t;
  fpc_pre_s_t s;
  fpc_pre_s_t next_s;
  logic [14:0] limit;

  always_comb
  begin
    next_s = s;
    limit = pw.clk_slow ? 15'(SLOW_TICK_CYC - 1) : 15'(fpc_pkg::FAST_TICK_CYC - 1);
    next_s.tick = 1'b0;
    if (s.cnt >= limit)
    begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end
    else
    begin
      next_s.cnt = s.cnt + 15'h0001;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign pw.tick = s.tick;
endmodule
`default_nettype wire

// *** rtl/fpc_pwm_core.sv ***
// Purpose: pwm waveform and open-drain pin control
// Assumes: tick pulses at the master pwm clock rate
// Notes: period is 2n master ticks; pin enable high means pin pulled low
`timescale 1ns/10ps
`default_nettype none
module fpc_pwm_core (
  input wire logic mclk,
  input wire logic rst,
  fpc_pwm_if.core pw,
  output logic pin_out,
  output logic pin_oe
);
  typedef struct packed {
    logic [5:0] phase;
    logic oe;
  } fpc_core_s_t;
  fpc_core_s_t s;
  fpc_core_s_t next_s;
  logic [4:0] n_eff;
  logic [5:0] period;
  logic [11:0] prod;
  logic [5:0] on_ticks;
  logic fan_on;

  always_comb
  begin
    next_s = s;
    n_eff = (pw.div_n == 5'h00) ? 5'h01 : pw.div_n;
    period = {n_eff, 1'b0};
    prod = 12'(pw.duty) * 12'(period);
    // full scale must be exactly 100%, so it bypasses the truncating divide
    on_ticks = (pw.duty == fpc_pkg::DUTY_FULL) ? period : 6'(prod / 12'd63);
    fan_on = s.phase < on_ticks;
    if (pw.tick)
    begin
      next_s.phase = (s.phase >= period - 6'h01) ? 6'h00 : s.phase + 6'h01;
    end
    next_s.oe = pw.pol ? fan_on : ~fan_on;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s.phase <= '0;
      s.oe <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign pin_oe = s.oe;
  assign pin_out = 1'b0;
endmodule
`default_nettype wire

// *** rtl/fpc_pwm_if.sv ***
// Purpose: carries pwm settings and master clock tick between the control modules
// Assumes: single mclk domain
// Notes: ctl drives settings, pre makes the tick, core makes the pin
`timescale 1ns/10ps
`default_nettype none
interface fpc_pwm_if;
  logic tick;
  logic clk_slow;
  logic [5:0] duty;
  logic [4:0] div_n;
  logic pol;
  modport ctl (output clk_slow, output duty, output div_n, output pol);
  modport pre (input clk_slow, output tick);
  modport core (input tick, input duty, input div_n, input pol);
endinterface
`default_nettype wire

// *** tb/fpc_fan_model.sv ***
// Purpose: fan with pull-up on the pwm line and a tach speed flag
// Assumes: speed builds one step per driven-on cycle, decays when off
// Notes: ramp sets how long the fan needs to reach minimum speed
`timescale 1ns/10ps
`default_nettype none
module fpc_fan_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic pin_oe,
  input wire logic pol,
  input wire logic [15:0] ramp,
  output logic pin_level,
  output logic speed_ok
);
  logic [15:0] spin;
  // pull-up: a released line reads high
  assign pin_level = pin_oe ? 1'b0 : 1'b1;
  assign speed_ok = (spin >= ramp);
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      spin <= 16'h0;
    else if (pin_oe == pol)
      spin <= (spin == 16'hFFFF) ? spin : spin + 16'h1;
    else if (spin != 16'h0)
      spin <= spin - 16'h1;
  end
endmodule
`default_nettype wire

// *** tb/fpc_fan_pwm_sva.sv ***
// Purpose: port-level checker for the fan pwm control block
// Assumes: one mclk domain, rst asynchronous active high
// Notes: only the divisor is shadowed; duty and table state stay inside
`timescale 1ns/10ps
`default_nettype none
module fpc_fan_pwm_sva #(
  parameter int unsigned SPINUP_UNIT_CYC = fpc_pkg::SPINUP_UNIT_CYC_DEF
)(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic pwm_pin_out,
  input wire logic [1:0] tach_mode,
  input wire logic spinup_busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // longest startup is code 111, 64 units, plus one cycle of slack
  localparam int BUSY_MAX = SPINUP_UNIT_CYC * 64 + 1;
  logic [4:0] div_sh;
  // wide enough for the longest startup at the full-rate unit, so the bound cannot wrap
  logic [26:0] busy_cnt;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      div_sh <= fpc_pkg::DIV_RST;
      busy_cnt <= 27'h0;
    end
    else
    begin
      if (reg_wr && reg_addr == fpc_pkg::ADDR_DIV)
        div_sh <= reg_wdata[4:0];
      busy_cnt <= spinup_busy ? busy_cnt + 27'h0000001 : 27'h0;
    end
  end
  sequence cfg_wr_fast;
    reg_wr && reg_addr == fpc_pkg::ADDR_CFG && !reg_wdata[fpc_pkg::CFG_CLK_BIT];
  endsequence
  sequence cfg_wr_slow;
    reg_wr && reg_addr == fpc_pkg::ADDR_CFG && reg_wdata[fpc_pkg::CFG_CLK_BIT];
  endsequence
  sequence cfg_quiet;
    !(reg_wr && reg_addr == fpc_pkg::ADDR_CFG);
  endsequence
  property slow_mode_p;
    logic [1:0] m;
    (cfg_wr_slow, m = reg_wdata[1:0]) ##1 cfg_quiet |=> tach_mode == m;
  endproperty
  chk_pin_data_low: assert property (pwm_pin_out == 1'b0)
    else $error("open-drain data line driven high");
  chk_upper_bits_zero: assert property (reg_rd && reg_addr inside {[8'h4A:8'h4C]} |=> reg_rdata[7:6] == 2'h0)
    else $error("unused upper bits read nonzero");
  chk_div_readback: assert property (reg_rd && reg_addr == fpc_pkg::ADDR_DIV |=> reg_rdata == {3'h0, $past(div_sh)})
    else $error("divisor readback wrong");
  chk_reserved_reads_zero: assert property (reg_rd && reg_addr == fpc_pkg::ADDR_CFG |=> reg_rdata[2] == 1'b0)
    else $error("reserved config bit reads one");
  chk_unmapped_zero: assert property (reg_rd && !(reg_addr inside {[8'h4A:8'h4D], [8'h50:8'h5F]})
    |=> reg_rdata == 8'h00)
    else $error("unmapped address reads nonzero");
  chk_busy_duty_zero: assert property (reg_rd && reg_addr == fpc_pkg::ADDR_DUTY && spinup_busy
    |=> reg_rdata == 8'h00)
    else $error("duty reads nonzero during startup");
  chk_fast_mode_trad: assert property (cfg_wr_fast ##1 cfg_quiet |=> tach_mode == fpc_pkg::MODE_TRAD)
    else $error("fast clock without traditional tach mode");
  chk_slow_mode: assert property (slow_mode_p)
    else $error("tach mode differs from programmed field");
  chk_busy_bound: assert property (busy_cnt <= BUSY_MAX)
    else $error("startup longer than longest duration");
endmodule
bind fpc_fan_pwm fpc_fan_pwm_sva #(.SPINUP_UNIT_CYC(SPINUP_UNIT_CYC)) u_sva (.mclk, .rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pwm_pin_out, .tach_mode, .spinup_busy);
`default_nettype wire

// *** tb/tb_fan_pwm_control_regs.sv ***
// Purpose: self-checking bench for the fan pwm control block
// Assumes: slow tick shortened to 20 cycles, startup unit to 10
// Notes: on-time counted over whole periods so phase does not matter
`timescale 1ns/10ps
`default_nettype none
module tb_fan_pwm_control_regs;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] r; int win; logic [15:0] on;} fpc_row_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] remote_temp = 8'h10;
  logic [15:0] ramp = 16'h8000;
  logic fan_pol = 1'b0;
  logic [7:0] reg_rdata;
  logic tach_min_reached;
  logic pwm_pin_in;
  logic pwm_pin_out;
  logic pwm_pin_oe;
  logic [1:0] tach_mode;
  logic spinup_busy;
  logic [15:0] n;
  int n_errors = 0;
  int comparisons = 0;
  // rows: write a=d, read back r, then count fan-on cycles over win
  fpc_row_t rows [19] = '{'{8'h4B, 8'hF8, 8'h38, 0, 0}, '{8'h4A, 8'hFB, 8'h3B, 0, 0},
    '{8'h4D, 8'hFF, 8'h1F, 0, 0}, '{8'h4E, 8'hFF, 8'h00, 0, 0}, '{8'h60, 8'hFF, 8'h00, 0, 0},
    '{8'h50, 8'hFF, 8'h7F, 0, 0}, '{8'h51, 8'hFF, 8'h3F, 0, 0}, '{8'h4A, 8'h28, 8'h28, 0, 0},
    '{8'h4D, 8'h01, 8'h01, 0, 0}, '{8'h4C, 8'hFF, 8'h3F, 240, 240}, '{8'h4C, 8'h20, 8'h20, 240, 120},
    '{8'h4D, 8'h00, 8'h00, 240, 120}, '{8'h4D, 8'h03, 8'h03, 240, 120}, '{8'h4A, 8'h38, 8'h38, 0, 0},
    '{8'h4C, 8'h15, 8'h15, 240, 80}, '{8'h4C, 8'h00, 8'h00, 240, 0}, '{8'h4A, 8'h23, 8'h23, 0, 0},
    '{8'h4D, 8'h01, 8'h01, 0, 0}, '{8'h4C, 8'h20, 8'h20, 276, 138}};
  always #20 mclk = ~mclk;
  fpc_fan_pwm #(.SLOW_TICK_CYC(20), .SPINUP_UNIT_CYC(10)) DUT (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .remote_temp(remote_temp),
    .tach_min_reached(tach_min_reached), .pwm_pin_in(pwm_pin_in), .pwm_pin_out(pwm_pin_out),
    .pwm_pin_oe(pwm_pin_oe), .tach_mode(tach_mode), .spinup_busy(spinup_busy));
  fpc_fan_model fan (.mclk(mclk), .rst(rst), .pin_oe(pwm_pin_oe), .pol(fan_pol), .ramp(ramp),
    .pin_level(pwm_pin_in), .speed_ok(tach_min_reached));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
    // idle edge, so a following write never re-raises the strobe in the same time step
    step(1);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    step(1);
    reg_rd = 1'b0;
    step(1);
    check({8'h0, reg_rdata}, {8'h0, e}, "rdata");
  endtask
  task automatic on_count(input int win, input logic pol, output logic [15:0] c);
    c = 16'h0;
    // sample after the edge has settled, never in the launching time step
    repeat (win)
    begin
      step(1);
      c = c + {15'h0, pwm_pin_oe === pol};
    end
  endtask
  initial
  begin
    #(40 * 20000);
    n_errors++;
    report_and_stop();
  end
  initial
  begin
    step(5);
    rst = 1'b0;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      if (rows[i].a == fpc_pkg::ADDR_CFG)
        fan_pol = rows[i].d[fpc_pkg::CFG_POL_BIT];
      rdchk(rows[i].a, rows[i].r);
      if (rows[i].a == fpc_pkg::ADDR_CFG)
        check({14'h0, tach_mode},
          {14'h0, rows[i].d[fpc_pkg::CFG_CLK_BIT] ? rows[i].d[1:0] : fpc_pkg::MODE_TRAD}, "tach mode");
      if (rows[i].win != 0)
      begin
        step(300);
        on_count(rows[i].win, fan_pol, n);
        check(n, rows[i].on, "on cycles");
      end
    end
    $display("register and waveform rows done");
    rst = 1'b1;
    fan_pol = 1'b0;
    step(5);
    rst = 1'b0;
    check({15'h0, pwm_pin_oe}, 16'h1, "oe");
    rdchk(fpc_pkg::ADDR_CFG, fpc_pkg::CFG_RST);
    rdchk(fpc_pkg::ADDR_SU, fpc_pkg::SU_RST);
    rdchk(fpc_pkg::ADDR_DUTY, 8'h00);
    rdchk(fpc_pkg::ADDR_DIV, 8'h17);
    $display("reset values done");
    wr(fpc_pkg::ADDR_SU, 8'h09);
    wr(8'h50, 8'h28);
    wr(8'h51, 8'h2A);
    remote_temp = 8'h28;
    // table loaded, hand duty back to it
    wr(fpc_pkg::ADDR_CFG, 8'h08);
    rdchk(fpc_pkg::ADDR_DUTY, 8'h00);
    wr(fpc_pkg::ADDR_DUTY, 8'h11);
    wr(8'h50, 8'h00);
    rdchk(fpc_pkg::ADDR_DUTY, 8'h00);
    rdchk(8'h50, 8'h28);
    remote_temp = 8'h29;
    for (int i = 0; i < 6 && spinup_busy !== 1'b1; i++)
      step(1);
    check({15'h0, spinup_busy}, 16'h1, "busy");
    n = 16'h0;
    while (spinup_busy === 1'b1 && n < 16'd100)
    begin
      step(1);
      n = n + 16'h1;
    end
    check(n, 16'd10, "busy length");
    rdchk(fpc_pkg::ADDR_DUTY, 8'h2A);
    $display("table and timed startup done");
    wr(fpc_pkg::ADDR_CFG, 8'h28);
    wr(fpc_pkg::ADDR_DUTY, 8'h00);
    wr(fpc_pkg::ADDR_SU, 8'h27);
    for (int i = 0; i < 3000 && tach_min_reached !== 1'b0; i++)
      step(1);
    ramp = 16'd200;
    // tach input assumed enabled in the general configuration
    wr(fpc_pkg::ADDR_DUTY, 8'h05);
    step(2);
    check({15'h0, spinup_busy}, 16'h1, "busy");
    rdchk(fpc_pkg::ADDR_DUTY, 8'h00);
    on_count(100, 1'b0, n);
    check(n, 16'd100, "full on");
    for (int i = 0; i < 400 && tach_min_reached !== 1'b1; i++)
      step(1);
    step(3);
    check({15'h0, spinup_busy}, 16'h0, "busy");
    $display("speed-ended startup done");
    wr(fpc_pkg::ADDR_DUTY, 8'h00);
    wr(fpc_pkg::ADDR_SU, 8'h38);
    wr(fpc_pkg::ADDR_DUTY, 8'h3F);
    rdchk(fpc_pkg::ADDR_DUTY, 8'h3F);
    check({15'h0, spinup_busy}, 16'h0, "busy");
    $display("skipped startup done");
    // n=3 on the slow clock: 120-cycle period, window of four whole periods inside a 640-cycle startup
    wr(fpc_pkg::ADDR_DIV, 8'h03);
    for (int k = 0; k < 2; k++)
    begin
      wr(fpc_pkg::ADDR_DUTY, 8'h00);
      wr(fpc_pkg::ADDR_SU, (k == 0) ? 8'h17 : 8'h1F);
      wr(fpc_pkg::ADDR_DUTY, 8'h01);
      step(40);
      on_count(480, 1'b0, n);
      check(n, (k == 0) ? 16'd320 : 16'd480, "startup duty");
    end
    $display("startup duty codes done");
    report_and_stop();
  end
endmodule
`default_nettype wire
